// ### hdl/acr_pkg.sv
package acr_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int RESULT_BITS = 17;
  localparam int FILL_BITS = 4;
  localparam int EOC_POS = 23;
  localparam int FILLER_POS = 22;
  localparam int SIGN_POS = 21;
  localparam logic [4:0] LAST_FALL = 5'h17;
  localparam logic filler_bit = 1'b0;

  // ---------------------------------------------------------------
  // synchroniser lanes
  // ---------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam int LANE_CS = 4;
  localparam int LANE_SCK = 3;
  localparam int LANE_F0 = 2;
  localparam int LANE_RISE = 1;
  localparam int LANE_FALL = 0;
  // chip select idles high, everything else low
  localparam logic [SYNC_W-1:0] SYNC_INIT = 5'h10;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int INT_OSC_HZ = 307_200;
  localparam int OSC_DIV = (CLK_HZ + INT_OSC_HZ / 2) / INT_OSC_HZ;
  localparam int EXT_OSC_MAX_PERIOD_US = 100;
  localparam int EXT_IDLE_CYCLES = EXT_OSC_MAX_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int ISCK_DIV = 8;
  localparam int ISCK_HALF = ISCK_DIV / 2;
  localparam int CONV_TICKS_DEF = 45128;
  localparam int PWRUP_WAIT = 2;

  typedef enum logic [1:0] {
    ACR_CONV,
    ACR_SLEEP,
    ACR_OUTPUT
  } acr_state_t;

endpackage

// ### hdl/acr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acr_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [acr_pkg::SYNC_W-1:0] async_in,
  output logic [acr_pkg::SYNC_W-1:0] sync_out
);

  // first stage is read only by the second
  logic [acr_pkg::SYNC_W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= acr_pkg::SYNC_INIT;
      sync_out <= acr_pkg::SYNC_INIT;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ### hdl/acr_convclk.sv
`timescale 1ns/1ps
`default_nettype none
module acr_convclk #(
  parameter int EXT_IDLE = acr_pkg::EXT_IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_clock_select_s,
  output logic conv_tick,
  output logic ext_osc_active
);

  logic f0_prev_r;
  logic [15:0] osc_cnt_r;
  logic [15:0] idle_cnt_r;
  logic ext_r;
  logic f0_rise;

  assign f0_rise = conv_clock_select_s && !f0_prev_r;
  assign ext_osc_active = ext_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f0_prev_r <= 1'b0;
    end else begin
      f0_prev_r <= conv_clock_select_s;
    end
  end

  // ---------------------------------------------------------------
  // external clock detect
  // ---------------------------------------------------------------
  // a pin that stops toggling falls back to the internal oscillator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_r <= 1'b0;
      idle_cnt_r <= 16'h0000;
    end else if (f0_rise) begin
      ext_r <= 1'b1; // [R11]
      idle_cnt_r <= 16'h0000;
    end else if (idle_cnt_r == 16'(EXT_IDLE - 1)) begin
      ext_r <= 1'b0;
    end else begin
      idle_cnt_r <= idle_cnt_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // internal oscillator
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r <= 16'h0000;
    end else if (osc_cnt_r == 16'(acr_pkg::OSC_DIV - 1)) begin
      osc_cnt_r <= 16'h0000;
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_tick <= 1'b0;
    end else if (ext_r) begin
      conv_tick <= f0_rise; // [R11]
    end else begin
      conv_tick <= (osc_cnt_r == 16'(acr_pkg::OSC_DIV - 1)); // [R10]
    end
  end

endmodule
`default_nettype wire

// ### hdl/acr_readout.sv
// How it works
// R1: chip select low enables the interface and wakes the converter.
// R2: after each conversion go to sleep, stay while chip select is high.
// R3: chip select rising during output after the first rising clock aborts and starts a new conversion.
// R4: serial data output floats whenever chip select is high.
// R5: in conversion or sleep with chip select low, data pin shows status.
// R6: internal clock mode drives the clock pin during data output.
// R7: external clock mode: host supplies the clock, pin is an input.
// R8: weak pull-up on the clock pin whenever internal clock mode applies.
// R9: clock pin level at power-up or chip select fall picks the mode.
// R10: frequency-control low runs conversions from the internal oscillator.
// R11: external clock on frequency-control replaces the internal oscillator.
// R12: cycle conversion, sleep, data output in order, starting with conversion.
// R13: sleep holds the finished result in the shift register without loss.
// R14: chip select falling in sleep enters data output.
// R15: chip select high before first rising clock returns to sleep, result kept.
// R16: after first rising clock shift out; chip select high then starts conversion.
// R17: each result bit leaves on a falling serial clock edge.
// R18: modes come only from chip select and clock timing, no registers.
// R19: frame of 24 bits: three status, 17 result msb first, four zeros.
// R20: first bit is active-low done flag, updated live while selected.
// R21: clock edges past the 24th are ignored, ones go out meanwhile.
// R22: second bit always low; third is sign; with msb flags over/underrange.
// R23: conversion length is a parameter counted in conversion-clock ticks.
// R24: chip select, external clock and frequency-control pass two-stage synchronisers.
`timescale 1ns/1ps
`default_nettype none
module acr_readout #(
  parameter int CONV_TICKS = acr_pkg::CONV_TICKS_DEF,
  parameter int EXT_IDLE = acr_pkg::EXT_IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck_link_clk,
  input wire logic cs_n,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic sck_pullup_en,
  output logic serial_result_out,
  output logic serial_result_oe,
  input wire logic conv_clock_select_in,
  input wire logic sign_bit,
  input wire logic [acr_pkg::RESULT_BITS-1:0] result_in,
  output logic iface_enable,
  output logic converter_awake,
  output logic conv_busy,
  output logic ext_sck_mode,
  output logic ext_osc_active
);

  // ---------------------------------------------------------------
  // link domain: sck edges become toggles
  // ---------------------------------------------------------------
  // toggles survive the crossing; a level pulse could be missed
  logic rise_tgl_r;
  logic fall_tgl_r;

  always_ff @(posedge sck_link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_tgl_r <= 1'b0;
    end else begin
      rise_tgl_r <= ~rise_tgl_r;
    end
  end

  always_ff @(negedge sck_link_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_tgl_r <= 1'b0;
    end else begin
      fall_tgl_r <= ~fall_tgl_r;
    end
  end

  // ---------------------------------------------------------------
  // synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [acr_pkg::SYNC_W-1:0] sync_s;
  logic cs_s;
  logic sck_lvl_s;
  logic cs_prev_r;
  logic rise_prev_r;
  logic fall_prev_r;
  logic cs_fall;
  logic cs_rise;
  logic ext_rise;
  logic ext_fall;
  logic conv_tick;

  acr_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({cs_n, sck_in, conv_clock_select_in, rise_tgl_r, fall_tgl_r}),
    .sync_out(sync_s)
  ); // [R24]

  acr_convclk #(
    .EXT_IDLE(EXT_IDLE)
  ) u_convclk (
    .clk(clk),
    .rst_n(rst_n),
    .conv_clock_select_s(sync_s[acr_pkg::LANE_F0]),
    .conv_tick(conv_tick),
    .ext_osc_active(ext_osc_active)
  );

  assign cs_s = sync_s[acr_pkg::LANE_CS];
  assign sck_lvl_s = sync_s[acr_pkg::LANE_SCK];
  assign cs_fall = !cs_s && cs_prev_r;
  assign cs_rise = cs_s && !cs_prev_r;
  assign ext_rise = sync_s[acr_pkg::LANE_RISE] != rise_prev_r;
  assign ext_fall = sync_s[acr_pkg::LANE_FALL] != fall_prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_r <= 1'b1;
      rise_prev_r <= 1'b0;
      fall_prev_r <= 1'b0;
    end else begin
      cs_prev_r <= cs_s;
      rise_prev_r <= sync_s[acr_pkg::LANE_RISE];
      fall_prev_r <= sync_s[acr_pkg::LANE_FALL];
    end
  end

  // ---------------------------------------------------------------
  // serial clock mode
  // ---------------------------------------------------------------
  logic mode_ext_r;
  logic [1:0] pwrup_cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrup_cnt_r <= 2'h0;
    end else if (pwrup_cnt_r != 2'(acr_pkg::PWRUP_WAIT + 1)) begin
      pwrup_cnt_r <= pwrup_cnt_r + 2'h1;
    end
  end

  // the pin level is caught once the synchroniser has filled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ext_r <= 1'b0;
    end else if (pwrup_cnt_r == 2'(acr_pkg::PWRUP_WAIT) || cs_fall) begin
      mode_ext_r <= sck_lvl_s; // [R9] [R18]
    end
  end

  assign ext_sck_mode = mode_ext_r;

  // ---------------------------------------------------------------
  // cycle state machine
  // ---------------------------------------------------------------
  acr_pkg::acr_state_t state_r;
  logic [31:0] conv_cnt_r;
  logic started_r;
  logic [4:0] bit_cnt_r;
  logic [acr_pkg::FRAME_BITS-1:0] frame_r;
  logic sck_rise;
  logic sck_fall;
  logic conv_done;
  logic isck_r;
  logic [1:0] isck_cnt_r;
  logic isck_rise;
  logic isck_fall;
  logic isck_step;

  // own edges in internal mode, host edges in external mode
  assign sck_rise = mode_ext_r ? ext_rise : isck_rise; // [R7]
  assign sck_fall = mode_ext_r ? ext_fall : isck_fall;
  assign conv_done = state_r == acr_pkg::ACR_CONV && conv_tick && conv_cnt_r == 32'(CONV_TICKS - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= acr_pkg::ACR_CONV; // [R12]
    end else begin
      unique case (state_r)
        acr_pkg::ACR_CONV: begin
          if (conv_done) begin
            state_r <= acr_pkg::ACR_SLEEP; // [R2]
          end
        end
        acr_pkg::ACR_SLEEP: begin
          if (!cs_s) begin
            state_r <= acr_pkg::ACR_OUTPUT; // [R14] [R1]
          end
        end
        acr_pkg::ACR_OUTPUT: begin
          if (cs_rise && !started_r) begin
            state_r <= acr_pkg::ACR_SLEEP; // [R15]
          end else if (cs_rise) begin
            state_r <= acr_pkg::ACR_CONV; // [R3] [R16]
          end else if (started_r && sck_fall && bit_cnt_r == acr_pkg::LAST_FALL) begin
            state_r <= acr_pkg::ACR_CONV; // [R19] [R21]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_r <= 32'h0000_0000;
    end else if (state_r != acr_pkg::ACR_CONV) begin
      conv_cnt_r <= 32'h0000_0000;
    end else if (conv_tick) begin
      conv_cnt_r <= conv_cnt_r + 32'h0000_0001; // [R23]
    end
  end

  // ---------------------------------------------------------------
  // frame shift register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_r <= 1'b0;
    end else if (state_r != acr_pkg::ACR_OUTPUT) begin
      started_r <= 1'b0;
    end else if (sck_rise) begin
      started_r <= 1'b1; // [R16]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 5'h00;
    end else if (state_r != acr_pkg::ACR_OUTPUT) begin
      bit_cnt_r <= 5'h00;
    end else if (started_r && sck_fall) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  logic filler_bit_c;
  assign filler_bit_c = acr_pkg::filler_bit;

  // done flag low, filler low, sign, result, zero fill
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= 24'h00_0000;
    end else if (conv_done) begin
      frame_r <= {1'b0, filler_bit_c, sign_bit, result_in, 4'h0}; // [R19] [R22]
    end else if (state_r == acr_pkg::ACR_OUTPUT && started_r && sck_fall) begin // [R13]
      frame_r <= {frame_r[acr_pkg::FRAME_BITS-2:0], 1'b1}; // [R17]
    end
  end

  // ---------------------------------------------------------------
  // internal serial clock
  // ---------------------------------------------------------------
  // idles high on the pull-up; first step is the falling edge
  assign isck_step = !mode_ext_r && state_r == acr_pkg::ACR_OUTPUT && !cs_s && conv_tick &&
                     isck_cnt_r == 2'(acr_pkg::ISCK_HALF - 1);
  assign isck_rise = isck_step && !isck_r;
  assign isck_fall = isck_step && isck_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isck_cnt_r <= 2'h0;
      isck_r <= 1'b1;
    end else if (state_r != acr_pkg::ACR_OUTPUT || mode_ext_r) begin
      isck_cnt_r <= 2'h0;
      isck_r <= 1'b1;
    end else if (conv_tick) begin
      isck_cnt_r <= isck_cnt_r + 2'h1;
      if (isck_step) begin
        isck_r <= ~isck_r; // [R6]
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_result_out <= 1'b1;
      serial_result_oe <= 1'b0;
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
      sck_pullup_en <= 1'b1;
    end else begin
      serial_result_oe <= !cs_s; // [R4]
      if (state_r == acr_pkg::ACR_OUTPUT) begin
        serial_result_out <= frame_r[acr_pkg::EOC_POS];
      end else begin
        serial_result_out <= state_r == acr_pkg::ACR_CONV; // [R5] [R20] [R21]
      end
      sck_out <= isck_r;
      sck_oe <= !mode_ext_r && state_r == acr_pkg::ACR_OUTPUT && !cs_s; // [R6]
      sck_pullup_en <= !mode_ext_r; // [R8]
    end
  end

  assign iface_enable = !cs_s; // [R1]
  assign converter_awake = state_r != acr_pkg::ACR_SLEEP;
  assign conv_busy = state_r == acr_pkg::ACR_CONV;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_sdo_float_high: assert property (cs_s |=> !serial_result_oe) // [R4]
    else $error("data pin driven while deselected");
  chk_conv_sleep_entry: assert property (conv_done |=> state_r == acr_pkg::ACR_SLEEP) // [R2]
    else $error("no sleep after conversion");
  chk_abort_restart: assert property (state_r == acr_pkg::ACR_OUTPUT && started_r && cs_rise
    |=> state_r == acr_pkg::ACR_CONV && conv_cnt_r == 32'h0000_0000) // [R3]
    else $error("abort did not restart conversion");
  chk_sleep_wake_out: assert property (state_r == acr_pkg::ACR_SLEEP && !cs_s
    |=> state_r == acr_pkg::ACR_OUTPUT) // [R14]
    else $error("select did not start output");
  chk_early_release_keep: assert property (state_r == acr_pkg::ACR_OUTPUT && !started_r && cs_rise
    |=> state_r == acr_pkg::ACR_SLEEP && $stable(frame_r)) // [R15]
    else $error("early release lost the result");
  chk_status_on_pin: assert property (state_r == acr_pkg::ACR_CONV && !cs_s
    |=> serial_result_out && serial_result_oe) // [R5]
    else $error("busy status not shown");
  chk_mode_latch_fall: assert property (cs_fall |=> mode_ext_r == $past(sck_lvl_s)) // [R9]
    else $error("clock mode not latched");
  chk_frame_end_conv: assert property (state_r == acr_pkg::ACR_OUTPUT && started_r && sck_fall &&
    bit_cnt_r == acr_pkg::LAST_FALL && !cs_rise |=> state_r == acr_pkg::ACR_CONV) // [R19]
    else $error("frame not ended after 24 bits");
  chk_sleep_holds: assert property (state_r == acr_pkg::ACR_SLEEP && cs_s
    |=> state_r == acr_pkg::ACR_SLEEP && $stable(frame_r)) // [R13]
    else $error("sleep result disturbed");
  chk_sck_drive_mode: assert property (sck_oe |-> !mode_ext_r && $past(state_r) == acr_pkg::ACR_OUTPUT) // [R6]
    else $error("clock driven outside internal output");
  chk_frame_status_bits: assert property (conv_done
    |=> !frame_r[acr_pkg::EOC_POS] && !frame_r[acr_pkg::FILLER_POS] && frame_r[3:0] == 4'h0) // [R22]
    else $error("frame status bits wrong");
  chk_power_mode_latch: assert property (pwrup_cnt_r == 2'(acr_pkg::PWRUP_WAIT)
    |=> mode_ext_r == $past(sck_lvl_s)) // [R9]
    else $error("power-up clock mode not latched");
  chk_pullup_follows_mode: assert property (sck_pullup_en != $past(mode_ext_r)) // [R8]
    else $error("pull-up does not follow clock mode");
  chk_oe_follows_cs: assert property (serial_result_oe != $past(cs_s)) // [R4]
    else $error("data pin enable does not follow select");

endmodule
`default_nettype wire

// ### verification/acr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
  input wire logic lclk,
  input wire logic sck_wire,
  input wire logic sdo_wire,
  output logic cs_n,
  output logic host_sck,
  output logic host_oe
);
  int timeouts;

  // power-up strap low: internal clock mode
  initial begin
    cs_n = 1'b1;
    host_sck = 1'b0;
    host_oe = 1'b1;
    timeouts = 0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge lclk);
  endtask

  task automatic strap(input logic lvl);
    ticks(1);
    host_oe <= 1'b1;
    host_sck <= lvl;
  endtask

  // pin level is held across the falling chip select, then released in internal mode
  task automatic cs_fall(input logic ext);
    strap(ext);
    ticks(2);
    cs_n <= 1'b0;
    ticks(6);
    host_oe <= ext;
  endtask

  task automatic cs_rise();
    ticks(1);
    cs_n <= 1'b1;
    ticks(2);
  endtask

  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    while (sck_wire !== lvl && n < 4000) begin
      ticks(1);
      n++;
    end
    if (n >= 4000) begin
      timeouts++;
    end
  endtask

  // half period of 6 link ticks, so the data pin has settled before each rise
  task automatic shift_ext(input int nbits, output logic [31:0] d);
    d = 32'h0;
    host_sck <= 1'b0;
    ticks(6);
    for (int i = 0; i < nbits; i++) begin
      d = {d[30:0], sdo_wire};
      host_sck <= 1'b1;
      ticks(6);
      host_sck <= 1'b0;
      ticks(6);
    end
  endtask

  task automatic shift_int(input int nbits, output logic [31:0] d);
    d = 32'h0;
    wait_lvl(1'b0);
    for (int i = 0; i < nbits; i++) begin
      wait_lvl(1'b1);
      d = {d[30:0], sdo_wire};
      wait_lvl(1'b0);
    end
  endtask
endmodule
`default_nettype wire

// ### verification/adc_cycle_serial_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_cycle_serial_readout_tb_top;
  localparam logic [16:0] RES_A = 17'h1a5c3;
  localparam logic [16:0] RES_B = 17'h0f0f1;
  localparam logic [16:0] RES_C = 17'h04b2d;
  logic clk, lclk, rst_n, cs_n, host_sck, host_oe, sck_out, sck_oe, sck_pullup_en;
  logic serial_result_out, serial_result_oe, sign_bit, osc_run;
  logic conv_clock_select_in = 1'b0;
  logic iface_enable, converter_awake, conv_busy, ext_sck_mode, ext_osc_active;
  logic sck_last = 1'b0;
  logic sdo_last = 1'b0;
  logic [16:0] result_in;
  logic [3:0] osc_cnt = 4'h0;
  logic [31:0] d;
  wire logic sck_wire;
  wire logic sdo_wire;
  int err_count = 0;
  int compares = 0;

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // undriven lines toggle each cycle so a stale level never passes
  assign sck_wire = sck_oe ? sck_out : host_oe ? host_sck : sck_pullup_en ? 1'b1 : ~sck_last;
  assign sdo_wire = serial_result_oe ? serial_result_out : ~sdo_last;
  always @(posedge clk) begin
    sck_last <= sck_wire;
    sdo_last <= sdo_wire;
  end
  // external conversion clock: one rising edge every 16 cycles
  always @(posedge clk) begin
    osc_cnt <= osc_run ? osc_cnt + 4'h1 : 4'h0;
    conv_clock_select_in <= osc_run & osc_cnt[3];
  end

  initial begin
    clk = 1'b0;
    lclk = 1'b0;
  end
  always #4 clk = ~clk;
  always #6 lclk = ~lclk;

  acr_readout #(.CONV_TICKS(20), .EXT_IDLE(64)) i_acr_readout (
    .clk(clk), .rst_n(rst_n), .sck_link_clk(sck_wire), .cs_n(cs_n), .sck_in(sck_wire),
    .sck_out(sck_out), .sck_oe(sck_oe), .sck_pullup_en(sck_pullup_en),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .conv_clock_select_in(conv_clock_select_in), .sign_bit(sign_bit), .result_in(result_in),
    .iface_enable(iface_enable), .converter_awake(converter_awake), .conv_busy(conv_busy),
    .ext_sck_mode(ext_sck_mode), .ext_osc_active(ext_osc_active)
  );

  acr_host_model i_acr_host_model (
    .lclk(lclk), .sck_wire(sck_wire), .sdo_wire(sdo_wire),
    .cs_n(cs_n), .host_sck(host_sck), .host_oe(host_oe)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] frame(input logic s, input logic [16:0] r);
    return {1'b0, 1'b0, s, r, 4'h0};
  endfunction

  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // checks land on the falling edge, after the rising edge's updates
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl && n < 12000) begin
      cycles(1);
      n++;
    end
    check("busy_wait", 32'h0, (n >= 12000) ? 32'h1 : 32'h0);
    if (n >= 12000) begin
      complete_run();
    end
  endtask

  task automatic host_ok();
    check("host_timeouts", 32'h0, i_acr_host_model.timeouts);
    if (i_acr_host_model.timeouts != 0) begin
      complete_run();
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up();
    cycles(1);
    check("busy", 32'h1, conv_busy);
    check("sdo_oe", 32'h0, serial_result_oe);
    check("ext_mode", 32'h0, ext_sck_mode);
    check("pullup", 32'h1, sck_pullup_en);
    check("ext_osc", 32'h0, ext_osc_active);
    cycles(7000);
    check("busy_len", 32'h1, conv_busy);
    wait_busy(1'b0);
    cycles(200);
    check("asleep", 32'h0, converter_awake);
    check("sdo_oe", 32'h0, serial_result_oe);
  endtask

  task automatic t_early_abort();
    i_acr_host_model.cs_fall(1'b1);
    cycles(6);
    check("iface", 32'h1, iface_enable);
    check("awake", 32'h1, converter_awake);
    check("ext_mode", 32'h1, ext_sck_mode);
    check("done_n", 32'h0, sdo_wire);
    @(posedge clk);
    result_in <= RES_B;
    sign_bit <= 1'b0;
    i_acr_host_model.cs_rise();
    cycles(8);
    check("asleep", 32'h0, converter_awake);
    check("busy", 32'h0, conv_busy);
    check("sdo_oe", 32'h0, serial_result_oe);
  endtask

  task automatic t_frame_ext();
    i_acr_host_model.cs_fall(1'b1);
    i_acr_host_model.shift_ext(28, d);
    host_ok();
    check("frame_a", {4'h0, frame(1'b1, RES_A), 4'hf}, d);
    cycles(2);
    check("busy", 32'h1, conv_busy);
    i_acr_host_model.cs_rise();
  endtask

  task automatic t_status_mid();
    i_acr_host_model.cs_fall(1'b1);
    cycles(4);
    check("status", 32'h1, sdo_wire);
    check("awake", 32'h1, converter_awake);
    wait_busy(1'b0);
    cycles(8);
    check("done_n", 32'h0, sdo_wire);
    i_acr_host_model.shift_ext(6, d);
    host_ok();
    check("partial", {26'h0, 3'h0, RES_B[16:14]}, d);
    @(posedge clk);
    result_in <= RES_C;
    sign_bit <= 1'b1;
    osc_run <= 1'b1;
    i_acr_host_model.cs_rise();
    cycles(8);
    check("abort", 32'h1, conv_busy);
    check("sdo_oe", 32'h0, serial_result_oe);
  endtask

  task automatic t_internal();
    cycles(100);
    check("ext_osc", 32'h1, ext_osc_active);
    wait_busy(1'b0);
    i_acr_host_model.cs_fall(1'b0);
    cycles(2);
    check("ext_mode", 32'h0, ext_sck_mode);
    check("pullup", 32'h1, sck_pullup_en);
    check("sck_oe", 32'h1, sck_oe);
    i_acr_host_model.shift_int(24, d);
    host_ok();
    check("frame_c", {8'h0, frame(1'b1, RES_C)}, d);
    i_acr_host_model.cs_rise();
    @(posedge clk);
    osc_run <= 1'b0;
    cycles(200);
    check("ext_osc", 32'h0, ext_osc_active);
  endtask

  // second reset with the pin strapped high: external mode from power-up
  task automatic t_reset_mid();
    i_acr_host_model.strap(1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cycles(1);
    check("busy", 32'h1, conv_busy);
    check("awake", 32'h1, converter_awake);
    check("sdo_oe", 32'h0, serial_result_oe);
    cycles(3);
    check("ext_mode", 32'h1, ext_sck_mode);
    check("pullup", 32'h0, sck_pullup_en);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    osc_run = 1'b0;
    sign_bit = 1'b1;
    result_in = RES_A;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up();
    t_early_abort();
    t_frame_ext();
    t_status_mid();
    t_internal();
    t_reset_mid();
    complete_run();
  end

  // last resort against a hang outside the bounded waits
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
